/* File: sleep_irq_pkg.sv */
package sleep_irq_pkg;

  // register byte offsets on the bus
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h4;
  localparam logic [3:0] OFF_STATE = 4'h8;

  // reset values and writable control bits
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [7:0] CONTROL_WRITABLE = 8'h3f;

  // sense field encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_RSVD = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // wake reset delay, least time so rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_RESET_DELAY_NS = 16000;
  localparam int WAKE_RESET_DELAY_CYCLES =
    (WAKE_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01,
    ST_PDOWN = 2'b10
  } sleep_state_type;

  // control register layout, msb first
  typedef struct packed {
    logic [1:0] reserved;
    logic sleep_arm;
    logic sleep_depth_select;
    logic pin_b_sense_hi;
    logic pin_b_sense_lo;
    logic pin_a_sense_hi;
    logic pin_a_sense_lo;
  } control_type;

  // state register layout, msb first
  typedef struct packed {
    logic pin_b_level;
    logic pin_a_level;
    logic sleep_ignored;
    logic [1:0] request;
    logic [1:0] state;
  } state_view_type;

endpackage

/* File: sleep_and_ext_irq_control.sv */
`timescale 1ns/1ps
`default_nettype none
module sleep_and_ext_irq_control #(
  parameter int ADDR_W = 4,
  parameter int WAKE_DELAY_CYCLES = sleep_irq_pkg::WAKE_RESET_DELAY_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // processor core side
  input wire logic SLEEP_EXEC,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic [1:0] IRQ_ACK,
  input wire logic WAKE_INTERNAL,
  input wire logic WDT_RESET,
  output logic [1:0] IRQ_REQ,
  output logic CPU_HALT,
  output logic OSC_STOP,
  output logic WAKE_PULSE,
  output logic CORE_RESET,
  // pins
  input wire logic EXT_IRQ_PIN_A,
  input wire logic EXT_IRQ_PIN_B,
  input wire logic EXT_RESET_N
);
  import sleep_irq_pkg::*;

  localparam int CNT_W = $clog2(WAKE_DELAY_CYCLES + 1);

  // refused at elaboration: the decode needs four offset bits
  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W must be at least 4");
  end
  if (WAKE_DELAY_CYCLES < 1) begin : g_delay_check
    $error("WAKE_DELAY_CYCLES must be at least 1");
  end

  control_type control_reg;
  logic [1:0] mask_reg;
  sleep_state_type state_reg;
  logic sleep_ignored_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [1:0] edge_flag_reg;
  logic [1:0] level_req;
  logic [1:0] cond;
  logic [1:0] sense [2];
  logic [1:0] pin_level;
  logic ext_reset_active;
  logic [CNT_W-1:0] wake_cnt_reg;
  logic pdown_level_wake;
  logic reset_wake;
  logic idle_wake;
  logic wake_pulse_reg;
  logic core_reset_reg;

  // axi bookkeeping
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic [3:0] wr_off;
  logic [3:0] rd_off;
  logic [31:0] rd_next;
  logic rd_ok;
  state_view_type state_view;

  // pins pass two flops; pad level is used whatever the pin direction
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {EXT_RESET_N, EXT_IRQ_PIN_B, EXT_IRQ_PIN_A};
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_level = sync2_reg[1:0];
  assign ext_reset_active = ~sync2_reg[2];
  assign sense[0] = {control_reg.pin_a_sense_hi, control_reg.pin_a_sense_lo};
  assign sense[1] = {control_reg.pin_b_sense_hi, control_reg.pin_b_sense_lo};

  // previous sample for edge detection
  always_ff @(posedge CLK) begin
    if (RST) begin
      prev_reg <= 2'h3;
    end else begin
      prev_reg <= pin_level;
    end
  end

  // per pin sense decode and edge flag
  for (genvar p = 0; p < 2; p++) begin : g_pin
    always_comb begin
      level_req[p] = 1'b0;
      cond[p] = 1'b0;
      unique case (sense[p])
        SENSE_LOW: level_req[p] = ~pin_level[p];
        SENSE_RSVD: cond[p] = 1'b0;
        SENSE_FALL: cond[p] = prev_reg[p] & ~pin_level[p];
        SENSE_RISE: cond[p] = ~prev_reg[p] & pin_level[p];
      endcase
    end

    // set wins over the core's acknowledge
    always_ff @(posedge CLK) begin
      if (RST) begin
        edge_flag_reg[p] <= 1'b0;
      end else if (cond[p]) begin
        edge_flag_reg[p] <= 1'b1;
      end else if (IRQ_ACK[p]) begin
        edge_flag_reg[p] <= 1'b0;
      end
    end
  end

  // requests to the core are gated by the global flag and the mask
  assign IRQ_REQ = (edge_flag_reg | level_req) & mask_reg & {2{GLOBAL_IRQ_EN}};

  // power-down wake needs a masked low level held past the reset delay
  assign pdown_level_wake = |(level_req & mask_reg) & GLOBAL_IRQ_EN;

  always_ff @(posedge CLK) begin
    if (RST) begin
      wake_cnt_reg <= '0;
    end else if (state_reg != ST_PDOWN || !pdown_level_wake) begin
      wake_cnt_reg <= '0;
    end else if (wake_cnt_reg != CNT_W'(WAKE_DELAY_CYCLES)) begin
      wake_cnt_reg <= wake_cnt_reg + 1'b1;
    end
  end

  assign reset_wake = WDT_RESET | ext_reset_active;
  assign idle_wake = (|IRQ_REQ) | WAKE_INTERNAL;

  // sleep state machine; only the cpu clock and oscillator are affected
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (SLEEP_EXEC && control_reg.sleep_arm) begin
            state_reg <= control_reg.sleep_depth_select ? ST_PDOWN : ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (reset_wake || idle_wake) begin
            state_reg <= ST_RUN;
          end
        end
        ST_PDOWN: begin
          // edge requests deliberately ignored here
          // the level must still stand when the count completes
          if (reset_wake
            || pdown_level_wake && wake_cnt_reg == CNT_W'(WAKE_DELAY_CYCLES)) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // unarmed sleep is a no-op; remember it for software
  always_ff @(posedge CLK) begin
    if (RST) begin
      sleep_ignored_reg <= 1'b0;
    end else if (state_reg == ST_RUN && SLEEP_EXEC) begin
      sleep_ignored_reg <= ~control_reg.sleep_arm;
    end
  end

  // one pulse on the cycle the cpu clock returns
  always_ff @(posedge CLK) begin
    if (RST) begin
      wake_pulse_reg <= 1'b0;
      core_reset_reg <= 1'b0;
    end else begin
      wake_pulse_reg <= state_reg != ST_RUN && (reset_wake || idle_wake
        && state_reg == ST_IDLE || pdown_level_wake
        && wake_cnt_reg == CNT_W'(WAKE_DELAY_CYCLES));
      core_reset_reg <= reset_wake;
    end
  end

  assign CPU_HALT = state_reg != ST_RUN;
  assign OSC_STOP = state_reg == ST_PDOWN;
  assign WAKE_PULSE = wake_pulse_reg;
  assign CORE_RESET = core_reset_reg;

  // write channel: address and data taken in either order
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_off = awaddr_reg[3:0];

  // registers change only by bus writes, so sleep leaves them intact
  always_ff @(posedge CLK) begin
    if (RST) begin
      control_reg <= CONTROL_RESET;
      mask_reg <= MASK_RESET;
    end else if (do_write && wstrb_reg[0] && (awaddr_reg >> 4) == '0) begin
      if (wr_off == OFF_CONTROL) begin
        control_reg <= wdata_reg[7:0] & CONTROL_WRITABLE;
      end
      if (wr_off == OFF_MASK) begin
        mask_reg <= wdata_reg[1:0];
      end
    end
  end

  // write response
  always_ff @(posedge CLK) begin
    if (RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_off == OFF_CONTROL || wr_off == OFF_MASK
        || wr_off == OFF_STATE) && (awaddr_reg >> 4) == '0
        ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // read decode; unmapped reads answer zero with an error
  assign state_view = '{pin_b_level: pin_level[1], pin_a_level: pin_level[0],
    sleep_ignored: sleep_ignored_reg, request: IRQ_REQ, state: state_reg};
  assign rd_off = S_AXI_ARADDR[3:0];

  always_comb begin
    rd_next = 32'h0;
    rd_ok = (S_AXI_ARADDR >> 4) == '0; // upper offset bits must be clear
    if (rd_off == OFF_CONTROL) begin
      rd_next = {24'h0, 2'h0, control_reg[5:0]};
    end else if (rd_off == OFF_MASK) begin
      rd_next = {30'h0, mask_reg};
    end else if (rd_off == OFF_STATE) begin
      rd_next = {25'h0, state_view};
    end else begin
      rd_ok = 1'b0;
    end
    if (!rd_ok) begin
      rd_next = 32'h0;
    end
  end

  // one read at a time; data registered
  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_next;
      rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

endmodule // sleep_and_ext_irq_control
`default_nettype wire

/* File: sleep_irq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sleep_irq_monitor #(
  parameter int WAKE_DELAY_CYCLES = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SLEEP_EXEC,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic WAKE_INTERNAL,
  input wire logic WDT_RESET,
  input wire logic EXT_RESET_N,
  input wire logic [1:0] IRQ_REQ,
  input wire logic CPU_HALT,
  input wire logic OSC_STOP,
  input wire logic WAKE_PULSE,
  input wire logic CORE_RESET
);
  int lo_cnt_reg;
  // run length of a standing request; a level wake needs a long one
  always_ff @(posedge CLK) begin
    if (RST || IRQ_REQ == 2'h0) begin
      lo_cnt_reg <= 0;
    end else begin
      lo_cnt_reg <= lo_cnt_reg + 1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  halt_cause_a: assert property ($rose(CPU_HALT) |-> $past(SLEEP_EXEC))
    else $error("halt without sleep instruction");
  osc_halt_a: assert property (OSC_STOP |-> CPU_HALT)
    else $error("oscillator stopped while cpu runs");
  irq_gate_a: assert property (IRQ_REQ != 2'h0 |-> GLOBAL_IRQ_EN)
    else $error("request with global flag clear");
  wake_mark_a: assert property (WAKE_PULSE == $fell(CPU_HALT))
    else $error("wake pulse not matching halt release");
  idle_wake_a: assert property (CPU_HALT && !OSC_STOP && (IRQ_REQ != 2'h0 || WAKE_INTERNAL)
    |=> !CPU_HALT)
    else $error("idle not left on request");
  wdt_wake_a: assert property (CPU_HALT && WDT_RESET |=> !CPU_HALT && CORE_RESET)
    else $error("watchdog reset did not wake");
  pin_reset_a: assert property (!EXT_RESET_N [*3] |=> CORE_RESET)
    else $error("reset pin not passed to core");
  // with no request standing, internal wakes keep power-down asleep
  pdown_quiet_a: assert property (OSC_STOP && IRQ_REQ == 2'h0 && !WDT_RESET
    && $past(EXT_RESET_N) && $past(EXT_RESET_N, 2) |=> OSC_STOP)
    else $error("power-down left without cause");
  pdown_slow_a: assert property ($fell(OSC_STOP)
    |-> CORE_RESET || lo_cnt_reg > WAKE_DELAY_CYCLES)
    else $error("level wake before reset delay");
endmodule // sleep_irq_monitor
bind sleep_and_ext_irq_control sleep_irq_monitor #(.WAKE_DELAY_CYCLES(WAKE_DELAY_CYCLES)) u_mon (
  .CLK, .RST, .SLEEP_EXEC, .GLOBAL_IRQ_EN, .WAKE_INTERNAL, .WDT_RESET, .EXT_RESET_N,
  .IRQ_REQ, .CPU_HALT, .OSC_STOP, .WAKE_PULSE, .CORE_RESET);
`default_nettype wire

/* File: ext_pin_source.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_pin_source (
  input wire logic clk,
  output logic pin_a,
  output logic pin_b
);
  // pads idle high, as on a pulled-up line
  initial begin
    pin_a = 1'b1;
    pin_b = 1'b1;
  end
  // level change just after an edge
  task automatic set(input logic b, input logic v);
    @(posedge clk);
    if (b) pin_b <= v;
    else pin_a <= v;
  endtask
  // low for n+1 cycles, longer than one clock so edges count
  task automatic pulse(input logic b, input int n);
    set(b, 1'b0);
    repeat (n) @(posedge clk);
    set(b, 1'b1);
  endtask
endmodule // ext_pin_source
`default_nettype wire

/* File: sleep_and_ext_irq_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sleep_and_ext_irq_control_tb;
  import sleep_irq_pkg::*;
  localparam int WD = 8;
  logic CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic SLEEP_EXEC, GLOBAL_IRQ_EN, WAKE_INTERNAL, WDT_RESET, EXT_RESET_N;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic CPU_HALT, OSC_STOP, WAKE_PULSE, CORE_RESET, EXT_IRQ_PIN_A, EXT_IRQ_PIN_B;
  logic [3:0] S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, IRQ_ACK, IRQ_REQ;
  int err_total, comparisons;

  sleep_and_ext_irq_control #(.WAKE_DELAY_CYCLES(WD)) dut (.CLK, .RST, .S_AXI_AWADDR,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .SLEEP_EXEC, .GLOBAL_IRQ_EN, .IRQ_ACK, .WAKE_INTERNAL, .WDT_RESET,
    .IRQ_REQ, .CPU_HALT, .OSC_STOP, .WAKE_PULSE, .CORE_RESET, .EXT_IRQ_PIN_A,
    .EXT_IRQ_PIN_B, .EXT_RESET_N);
  ext_pin_source pins (.clk(CLK), .pin_a(EXT_IRQ_PIN_A), .pin_b(EXT_IRQ_PIN_B));

  // free-running core clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic stop_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  // settle past the edge so flags launched there have landed
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // ready is looked at just after an edge; inputs hold, so it stands at the next
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [2:0] p;
    logic [2:0] t;
    logic [1:0] rs;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    p = 3'h7;
    while (p[0]) begin
      #1;
      t = p & {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID};
      rs = S_AXI_BRESP;
      @(posedge CLK);
      p = p & ~t;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= p;
    end
    chk("bresp", 32'(e), 32'(rs));
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] p;
    logic [1:0] t;
    logic [31:0] rd;
    logic [1:0] rs;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    p = 2'h3;
    while (p[0]) begin
      #1;
      t = p & {S_AXI_ARREADY, S_AXI_RVALID};
      rd = S_AXI_RDATA;
      rs = S_AXI_RRESP;
      @(posedge CLK);
      p = p & ~t;
      {S_AXI_ARVALID, S_AXI_RREADY} <= p;
    end
    chk("rdata", d, rd);
    chk("rresp", 32'(e), 32'(rs));
  endtask

  // w 0 pulses the acknowledges, w 2 the watchdog and internal wake lines
  task automatic pulse_in(input logic [1:0] m, input int w);
    @(posedge CLK);
    {WDT_RESET, WAKE_INTERNAL, IRQ_ACK} <= {2'h0, m} << w;
    @(posedge CLK);
    {WDT_RESET, WAKE_INTERNAL, IRQ_ACK} <= 4'h0;
  endtask

  // arm written right before the sleep instruction
  task automatic nap(input logic [7:0] c);
    axw(OFF_CONTROL, {24'h0, c}, RESP_OKAY);
    @(posedge CLK);
    SLEEP_EXEC <= 1'b1;
    @(posedge CLK);
    SLEEP_EXEC <= 1'b0;
    tick(1);
  endtask

  // hang guard, well beyond the few hundred cycles the tests take
  initial begin
    #300000;
    err_total++;
    stop_test();
  end

  initial begin
    {RST, SLEEP_EXEC, GLOBAL_IRQ_EN, WAKE_INTERNAL, WDT_RESET, EXT_RESET_N} = 6'h21;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, IRQ_ACK} = '0;
    S_AXI_WSTRB = 4'hf;
    {err_total, comparisons} = '0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    axr(OFF_CONTROL, 32'(CONTROL_RESET), RESP_OKAY);
    axw(OFF_CONTROL, 32'hff, RESP_OKAY);
    axr(OFF_CONTROL, 32'(CONTROL_WRITABLE), RESP_OKAY);
    axr(4'hc, 32'h0, RESP_SLVERR);
    axr(OFF_MASK, 32'(MASK_RESET), RESP_OKAY);
    axw(OFF_MASK, 32'h3, RESP_OKAY);
    GLOBAL_IRQ_EN <= 1'b1;
    // every sense code on both pins: low, reserved, fall, rise
    for (int i = 0; i < 8; i++) begin
      axw(OFF_CONTROL, 32'((i % 4) << (2 * (i / 4))), RESP_OKAY);
      pins.set(i[2], 1'b0);
      tick(4);
      chk("req_low", (i % 2 == 0) ? 32'(i / 4 + 1) : 32'h0, 32'(IRQ_REQ));
      pins.set(i[2], 1'b1);
      tick(4);
      chk("req_high", (i % 4 > 1) ? 32'(i / 4 + 1) : 32'h0, 32'(IRQ_REQ));
      pulse_in(2'(i / 4 + 1), 0);
    end
    GLOBAL_IRQ_EN <= 1'b0;
    pins.set(1'b0, 1'b0);
    tick(4);
    chk("gated", 32'h0, 32'(IRQ_REQ));
    axw(OFF_MASK, 32'h2, RESP_OKAY);
    GLOBAL_IRQ_EN <= 1'b1;
    tick(1);
    chk("masked", 32'h0, 32'(IRQ_REQ));
    axw(OFF_MASK, 32'h3, RESP_OKAY);
    tick(1);
    chk("level", 32'h1, 32'(IRQ_REQ));
    pins.set(1'b0, 1'b1);
    nap(8'h00);
    chk("no_arm", 32'h0, 32'(CPU_HALT));
    axr(OFF_STATE, 32'h70, RESP_OKAY);
    nap(8'h20);
    chk("idle", 32'h2, 32'({CPU_HALT, OSC_STOP}));
    pulse_in(2'h1, 2);
    #1;
    chk("idle_wake", 32'h1, 32'({CPU_HALT, WAKE_PULSE}));
    axr(OFF_CONTROL, 32'h20, RESP_OKAY);
    nap(8'h3a);
    chk("pdown", 32'h3, 32'({CPU_HALT, OSC_STOP}));
    pins.pulse(1'b0, 3);
    tick(6);
    chk("edge_sleep", 32'h1, 32'(OSC_STOP));
    @(posedge CLK);
    EXT_RESET_N <= 1'b0;
    tick(4);
    chk("pin_wake", 32'h1, 32'({CPU_HALT, CORE_RESET}));
    @(posedge CLK);
    EXT_RESET_N <= 1'b1;
    pulse_in(2'h1, 0);
    nap(8'h30);
    pins.pulse(1'b0, 4);
    tick(6);
    chk("short_low", 32'h1, 32'(OSC_STOP));
    pins.set(1'b0, 1'b0);
    tick(WD + 6);
    chk("level_wake", 32'h0, 32'({CPU_HALT, OSC_STOP}));
    pins.set(1'b0, 1'b1);
    nap(8'h30);
    pulse_in(2'h1, 2);
    #1;
    chk("int_sleep", 32'h1, 32'(OSC_STOP));
    pulse_in(2'h2, 2);
    #1;
    chk("wdt_wake", 32'h1, 32'({CPU_HALT, CORE_RESET}));
    stop_test();
  end
endmodule // sleep_and_ext_irq_control_tb
`default_nettype wire
